// [design/cbm_pkg.sv]
package cbm_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint WDT_STEP_NS   = 8192000;
  localparam longint PD_STEP_NS    = 64'd120000000000;
  localparam longint WDT_STEP_CYC  = WDT_STEP_NS / CLK_PERIOD_NS;
  localparam longint PD_STEP_CYC   = PD_STEP_NS / CLK_PERIOD_NS;
  localparam int     DIV_W         = 36;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int CMD_BITS   = 32;
  localparam int CONV_BITS  = 64;
  localparam int DEV_HI     = 31;
  localparam int DEV_LO     = 27;
  localparam int DIR_BIT    = 26;
  localparam int RADDR_HI   = 25;
  localparam int RADDR_LO   = 20;
  localparam int DATA_HI    = 19;
  localparam int DATA_LO    = 12;
  localparam int CRC_HI     = 11;
  localparam logic [11:0] CRC_POLY = 12'h683;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [5:0] A_CTRL1    = 6'h01;
  localparam logic [5:0] A_ADC_FUNC = 6'h02;
  localparam logic [5:0] A_PDT      = 6'h03;
  localparam logic [5:0] A_WDT      = 6'h04;
  localparam logic [5:0] A_WDT_KEY  = 6'h05;
  localparam logic [5:0] A_DEV_ADDR = 6'h06;
  localparam logic [5:0] A_RB_SEL   = 6'h3f;
  localparam int         HW_POWERDOWN_SELECT_BIT   = 2;
  localparam int         LOCK_BIT   = 7;
  localparam logic [7:0] ADC_FUNC_32 = 8'h04;
  localparam logic [7:0] WDT_RESET   = 8'h0c;
  localparam logic [7:0] WDT_KEY     = 8'h5a;
  localparam logic [4:0] DEV_RESET   = 5'h00;
  localparam logic [4:0] DEV_BCAST   = 5'h1f;

  typedef enum logic [1:0] {
    MODE_REG  = 2'b01,
    MODE_CONV = 2'b10
  } cbm_mode_e;

  typedef enum logic [2:0] {
    WD_IDLE = 3'b001,
    WD_ZERO = 3'b010,
    WD_KEY  = 3'b100
  } cbm_wdseq_e;

  typedef struct packed {
    logic [5:0]  chan1;
    logic [2:0]  life;
    logic [54:0] rest;
  } cbm_conv_s;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
  } cbm_wr_s;

endpackage

// [design/cbm_spi_ctrl.sv]
`timescale 1ns/1ps
// Functional notes
// - spi mode 1; sample input on falling, launch output on rising edge
// - chip select bursts of 32 or 16 clocks both accepted
// - register frames are 32 bits; conversion results are 64-bit words
// - 32-bit after reset, 64-bit on conversion start, back on 0x04 write
// - conversion words read once; reread gives zero with last life count
// - register address sits in frame bits 25..20
// - write data byte in frame bits 19..12; registers are eight bits
// - five-bit address, reset zero, assignable and lockable; 0x1f broadcast
// - bit 26 high makes next chain transfer one-way; host sclk <= 725 khz, host model runs 8 mhz (125 ns period)
// - bit 26 low makes next chain transfer two-way
// - commands with bad 12-bit crc are dropped unexecuted
// - crc over bits 31..12 with polynomial 0xb41 (koopman form)
// - readback select at 0x3f, then one zero frame per device
// - readback always returns selected register, no single-device read
// - watchdog steps of 8.192 ms, up to 255 steps (2088.96 ms); write restarts count
// - watchdog runs from reset with timeout code 0x0c
// - disable by wdt 0x00, key 0x5a, wdt 0x00; other command restarts
// - watchdog expiry forces full power-down until wake pin rises on a master, or reset
// - zero timeout while running expires unless nonzero written
// - hw power-down select bit selects full power-down, starts timer when delay is nonzero
// - timer expiry powers down slave if select bit still set
// - power-down timer two-minute steps, zero means no delay on a master; a slave needs nonzero
// - crc register cleared before each frame
module cbm_spi_ctrl
  import cbm_pkg::*;
#(
  parameter logic [DIV_W-1:0] WDT_STEP = DIV_W'(WDT_STEP_CYC),
  parameter logic [DIV_W-1:0] PD_STEP  = DIV_W'(PD_STEP_CYC)
) (
  input  wire logic      mclk,
  input  wire logic      rst,
  input  wire logic      spi_cs_n,
  input  wire logic      spi_sclk,
  input  wire logic      spi_sdi,
  output logic           spi_sdo,
  input  wire logic      io_supply_wake,
  input  wire logic      is_master,
  input  wire logic      conv_start,
  input  wire cbm_conv_s conv_data,
  input  wire logic      conv_valid,
  output logic           conv_ready,
  output cbm_wr_s        reg_wr,
  output logic           reg_wr_valid,
  output logic           chain_one_way,
  output logic           frame_64,
  output logic           full_powerdown
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [11:0] crc12(input logic [19:0] d);
    logic [11:0] c;
    logic        fb;
    c = '0;
    for (int i = 19; i >= 0; i--) begin
      fb = d[i] ^ c[11];
      c  = {c[10:0], 1'b0} ^ (fb ? CRC_POLY : 12'h000);
    end
    return c;
  endfunction

  function automatic logic edge_up(input logic now, input logic was);
    return now & ~was;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       sclk_sy;
    logic [1:0]       cs_sy;
    logic [1:0]       sdi_sy;
    logic [1:0]       wake_sy;
    logic             sclk_d;
    logic             cs_d;
    logic             wake_d;
    logic [4:0]       rx_cnt;
    logic [30:0]      rx_sh;
    logic [5:0]       tx_cnt;
    logic [63:0]      tx_sh;
    logic             sdo;
    cbm_mode_e        mode;
    logic [4:0]       dev_addr;
    logic             dev_lock;
    logic [7:0]       ctrl1;
    logic [7:0]       adc_func;
    logic [7:0]       powerdown_delay_timer;
    logic [7:0]       wdt;
    logic [5:0]       rb_sel;
    logic             one_way;
    logic             wd_en;
    cbm_wdseq_e       wd_seq;
    logic [DIV_W-1:0] wd_div;
    logic [7:0]       wd_cnt;
    logic             pd_run;
    logic [DIV_W-1:0] pd_div;
    logic [7:0]       pd_cnt;
    logic             pd_full;
    cbm_conv_s [1:0]  buf_q;
    logic             buf_wp;
    logic             buf_rp;
    logic [1:0]       buf_n;
    logic             buf_rdy;
    logic [2:0]       last_life;
    cbm_wr_s          wr;
    logic             wr_v;
  } cbm_state_s;

  cbm_state_s s;
  cbm_state_s next_s;

  always_comb begin
    logic        sclk_rise;
    logic        sclk_fall;
    logic        cs_fall;
    logic        wake_rise;
    logic        wake_fall;
    logic        bit_in;
    logic [31:0] cmd;
    logic        cmd_done;
    logic        accept;
    logic [5:0]  ra;
    logic [7:0]  rd;
    logic [7:0]  rv;
    logic        push;
    logic        pop;
    logic        wd_tick;
    logic        pd_tick;
    logic [11:0] rcrc;
    sclk_rise = 1'b0;
    sclk_fall = 1'b0;
    cs_fall   = 1'b0;
    wake_rise = 1'b0;
    wake_fall = 1'b0;
    bit_in    = 1'b0;
    cmd       = '0;
    cmd_done  = 1'b0;
    accept    = 1'b0;
    ra        = '0;
    rd        = '0;
    rv        = '0;
    push      = 1'b0;
    pop       = 1'b0;
    wd_tick   = 1'b0;
    pd_tick   = 1'b0;
    rcrc      = '0;
    next_s    = s;

    // ---------------------------------------------------------------
    // pin synchronisers and edge finding
    // ---------------------------------------------------------------
    next_s.sclk_sy = {s.sclk_sy[0], spi_sclk};
    next_s.cs_sy   = {s.cs_sy[0], spi_cs_n};
    next_s.sdi_sy  = {s.sdi_sy[0], spi_sdi};
    next_s.wake_sy = {s.wake_sy[0], io_supply_wake};
    next_s.sclk_d  = s.sclk_sy[1];
    next_s.cs_d    = s.cs_sy[1];
    next_s.wake_d  = s.wake_sy[1];
    sclk_rise = edge_up(s.sclk_sy[1], s.sclk_d) & ~s.cs_sy[1];
    sclk_fall = edge_up(s.sclk_d, s.sclk_sy[1]) & ~s.cs_sy[1];
    cs_fall   = edge_up(s.cs_d, s.cs_sy[1]);
    wake_rise = edge_up(s.wake_sy[1], s.wake_d);
    wake_fall = edge_up(s.wake_d, s.wake_sy[1]);
    bit_in    = s.sdi_sy[1];

    // ---------------------------------------------------------------
    // conversion buffer fill
    // ---------------------------------------------------------------
    push = conv_valid & s.buf_rdy;
    if (push) begin
      next_s.buf_q[s.buf_wp] = conv_data;
      next_s.buf_wp          = ~s.buf_wp;
    end
    if (conv_start) begin
      next_s.mode = MODE_CONV;
    end

    // ---------------------------------------------------------------
    // transmit: load at frame start, launch on rising edge
    // ---------------------------------------------------------------
    if (cs_fall && s.tx_cnt == '0) begin
      if (s.mode == MODE_CONV) begin
        if (s.buf_n != '0) begin
          pop                = 1'b1;
          next_s.tx_sh       = s.buf_q[s.buf_rp];
          next_s.last_life   = s.buf_q[s.buf_rp].life;
          next_s.buf_rp      = ~s.buf_rp;
        end else begin
          next_s.tx_sh = {6'h00, s.last_life, 55'h0};
        end
      end else begin
        unique case (s.rb_sel)
          A_CTRL1:    rv = s.ctrl1;
          A_ADC_FUNC: rv = s.adc_func;
          A_PDT:      rv = s.powerdown_delay_timer;
          A_WDT:      rv = s.wdt;
          A_DEV_ADDR: rv = {s.dev_lock, 2'b00, s.dev_addr};
          default:    rv = 8'h00;
        endcase
        rcrc = crc12({s.dev_addr, 1'b0, s.rb_sel, rv});
        next_s.tx_sh = {s.dev_addr, 1'b0, s.rb_sel, rv, rcrc, 32'h0};
      end
    end
    if (sclk_rise) begin
      next_s.sdo    = s.tx_sh[63];
      next_s.tx_sh  = {s.tx_sh[62:0], 1'b0};
      if (s.mode == MODE_CONV && s.tx_cnt != 6'(CONV_BITS - 1)) begin
        next_s.tx_cnt = s.tx_cnt + 6'd1;
      end else if (s.mode == MODE_REG && s.tx_cnt != 6'(CMD_BITS - 1)) begin
        next_s.tx_cnt = s.tx_cnt + 6'd1;
      end else begin
        next_s.tx_cnt = '0;
      end
    end
    next_s.buf_n = s.buf_n + 2'(push) - 2'(pop);
    next_s.buf_rdy = (next_s.buf_n != 2'd2);

    // ---------------------------------------------------------------
    // receive: sample on falling edge, 32 bits across bursts
    // ---------------------------------------------------------------
    if (sclk_fall) begin
      next_s.rx_sh  = {s.rx_sh[29:0], bit_in};
      next_s.rx_cnt = s.rx_cnt + 5'd1;
      if (s.rx_cnt == 5'(CMD_BITS - 1)) begin
        cmd_done = 1'b1;
        cmd      = {s.rx_sh, bit_in};
      end
    end

    // ---------------------------------------------------------------
    // command decode
    // ---------------------------------------------------------------
    ra = cmd[RADDR_HI:RADDR_LO];
    rd = cmd[DATA_HI:DATA_LO];
    accept = cmd_done && !s.pd_full && cmd != '0
           && (cmd[DEV_HI:DEV_LO] == s.dev_addr
               || cmd[DEV_HI:DEV_LO] == DEV_BCAST)
           && crc12(cmd[DEV_HI:DATA_LO]) == cmd[CRC_HI:0];
    next_s.wr_v = 1'b0;
    if (cmd_done && !s.pd_full) begin
      next_s.one_way = cmd[DIR_BIT];
    end
    if (accept) begin
      next_s.wr   = '{addr: ra, data: rd};
      next_s.wr_v = 1'b1;
      next_s.wd_seq = WD_IDLE;
      unique case (ra)
        A_CTRL1: begin
          next_s.ctrl1 = rd;
          if (rd[HW_POWERDOWN_SELECT_BIT] && !s.ctrl1[HW_POWERDOWN_SELECT_BIT] && s.powerdown_delay_timer != '0) begin
            next_s.pd_run = 1'b1;
            next_s.pd_div = '0;
            next_s.pd_cnt = '0;
          end
          if (!rd[HW_POWERDOWN_SELECT_BIT]) begin
            next_s.pd_run = 1'b0;
          end
        end
        A_ADC_FUNC: begin
          next_s.adc_func = rd;
          if (rd == ADC_FUNC_32) begin
            next_s.mode = MODE_REG;
            next_s.tx_cnt = '0;
          end
        end
        A_PDT: begin
          next_s.powerdown_delay_timer    = rd;
          next_s.pd_div = '0;
          next_s.pd_cnt = '0;
          next_s.pd_run = s.ctrl1[HW_POWERDOWN_SELECT_BIT] && rd != '0;
        end
        A_WDT: begin
          next_s.wdt    = rd;
          next_s.wd_div = '0;
          next_s.wd_cnt = '0;
          if (rd == '0 && s.wd_seq == WD_KEY) begin
            next_s.wd_en = 1'b0;
          end else if (rd == '0) begin
            next_s.wd_seq = WD_ZERO;
          end
        end
        A_WDT_KEY: begin
          if (rd == WDT_KEY && s.wd_seq == WD_ZERO) begin
            next_s.wd_seq = WD_KEY;
          end
        end
        A_DEV_ADDR: begin
          if (!s.dev_lock) begin
            next_s.dev_addr = rd[4:0];
            next_s.dev_lock = rd[LOCK_BIT];
          end
        end
        A_RB_SEL: begin
          next_s.rb_sel = rd[5:0];
        end
        default: begin
        end
      endcase
    end else if (cmd_done) begin
      next_s.wd_seq = WD_IDLE;
    end

    // ---------------------------------------------------------------
    // watchdog
    // ---------------------------------------------------------------
    if (s.wd_en && !s.pd_full && !(accept && ra == A_WDT)) begin
      if (s.wd_div == WDT_STEP - DIV_W'(1)) begin
        next_s.wd_div = '0;
        wd_tick       = 1'b1;
      end else begin
        next_s.wd_div = s.wd_div + DIV_W'(1);
      end
      if (wd_tick) begin
        next_s.wd_cnt = s.wd_cnt + 8'd1;
      end
      if (s.wd_cnt != '0 && s.wd_cnt >= s.wdt) begin
        next_s.pd_full = 1'b1;
      end
    end

    // ---------------------------------------------------------------
    // power-down timer and entry
    // ---------------------------------------------------------------
    if (s.pd_run && !s.pd_full && !(accept && ra == A_PDT)) begin
      if (s.pd_div == PD_STEP - DIV_W'(1)) begin
        next_s.pd_div = '0;
        pd_tick       = 1'b1;
      end else begin
        next_s.pd_div = s.pd_div + DIV_W'(1);
      end
      if (pd_tick) begin
        next_s.pd_cnt = s.pd_cnt + 8'd1;
      end
      if (s.pd_cnt >= s.powerdown_delay_timer) begin
        next_s.pd_run = 1'b0;
        if (is_master ? !s.wake_sy[1] : s.ctrl1[HW_POWERDOWN_SELECT_BIT]) begin
          next_s.pd_full = 1'b1;
        end
      end
    end
    if (is_master && wake_fall && s.ctrl1[HW_POWERDOWN_SELECT_BIT] && s.powerdown_delay_timer == '0) begin
      next_s.pd_full = 1'b1;
    end
    if (is_master && wake_rise && s.pd_full) begin
      next_s.pd_full = 1'b0;
      next_s.wd_en   = 1'b1;
      next_s.wdt     = WDT_RESET;
      next_s.wd_div  = '0;
      next_s.wd_cnt  = '0;
      next_s.wd_seq  = WD_IDLE;
      next_s.ctrl1   = '0;
      next_s.powerdown_delay_timer     = '0;
      next_s.mode    = MODE_REG;
      next_s.wr_v    = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s          <= '0;
      s.sclk_sy  <= 2'h0;
      s.cs_sy    <= 2'h3;
      s.cs_d     <= 1'b1;
      s.wake_sy  <= 2'h3;
      s.wake_d   <= 1'b1;
      s.mode     <= MODE_REG;
      s.dev_addr <= DEV_RESET;
      s.wdt      <= WDT_RESET;
      s.wd_en    <= 1'b1;
      s.wd_seq   <= WD_IDLE;
      s.one_way  <= 1'b1;
      s.buf_rdy  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign spi_sdo        = s.sdo;
  assign conv_ready     = s.buf_rdy;
  assign reg_wr         = s.wr;
  assign reg_wr_valid   = s.wr_v;
  assign chain_one_way  = s.one_way;
  assign frame_64       = (s.mode == MODE_CONV);
  assign full_powerdown = s.pd_full;

endmodule

// [sim/cbm_host_model.sv]
`timescale 1ns/1ps
// ---------------------------------------------------------------
// spi host, mode 1, sclk period 125 ns, sclk idles low outside frames, sdi toggles after chip select rises
// ---------------------------------------------------------------
module cbm_host_model (
  output logic      spi_cs_n,
  output logic      spi_sclk,
  output logic      spi_sdi,
  input  wire logic spi_sdo
);
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_sdi  = 1'b0;
  end

  function automatic logic [11:0] crc12(input logic [19:0] d);
    logic [11:0] c;
    c = 12'h000;
    for (int i = 19; i >= 0; i--) begin
      c = {c[10:0], 1'b0} ^ ((d[i] ^ c[11]) ? 12'h683 : 12'h000);
    end
    return c;
  endfunction

  function automatic logic [31:0] cmd(input logic [4:0] dev,
    input logic dir, input logic [5:0] a, input logic [7:0] d);
    return {dev, dir, a, d, crc12({dev, dir, a, d})};
  endfunction

  // 32-bit frames travel in tx[31:0]
  task automatic xfer(input logic [63:0] tx, input logic long_frame,
    input int burst, output logic [63:0] rx);
    int n;
    n = long_frame ? 64 : 32;
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      if ((n - 1 - i) % burst == 0) begin
        #137.3 spi_cs_n = 1'b0;
        #100;
      end
      spi_sclk = 1'b1;
      spi_sdi  = tx[i];
      #62.5 spi_sclk = 1'b0;
      rx[i] = spi_sdo;
      #62.5;
      if (i % burst == 0) begin
        #40 spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi;
      end
    end
  endtask
endmodule

// [sim/cbm_spi_ctrl_assertions.sv]
`timescale 1ns/1ps
module cbm_spi_ctrl_checker
  import cbm_pkg::*;
#(
  parameter logic [DIV_W-1:0] WDT_STEP = DIV_W'(WDT_STEP_CYC),
  parameter logic [DIV_W-1:0] PD_STEP  = DIV_W'(PD_STEP_CYC)
) (
  input wire logic      mclk,
  input wire logic      rst,
  input wire logic      spi_cs_n,
  input wire logic      spi_sclk,
  input wire logic      spi_sdi,
  input wire logic      spi_sdo,
  input wire logic      io_supply_wake,
  input wire logic      is_master,
  input wire logic      conv_start,
  input wire cbm_conv_s conv_data,
  input wire logic      conv_valid,
  input wire logic      conv_ready,
  input wire cbm_wr_s   reg_wr,
  input wire logic      reg_wr_valid,
  input wire logic      chain_one_way,
  input wire logic      frame_64,
  input wire logic      full_powerdown
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_wr_pulse;
    reg_wr_valid |=> !reg_wr_valid;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write pulse longer than one cycle");

  property p_wr_hold;
    !reg_wr_valid |-> $stable(reg_wr);
  endproperty
  a_wr_hold: assert property (p_wr_hold)
    else $error("write record changed without a pulse");

  property p_wr_cs;
    reg_wr_valid |-> !$past(spi_cs_n, 4);
  endproperty
  a_wr_cs: assert property (p_wr_cs)
    else $error("write accepted outside a selected frame");

  property p_pd_refuse;
    full_powerdown && $past(full_powerdown, 5) |-> !reg_wr_valid;
  endproperty
  a_pd_refuse: assert property (p_pd_refuse)
    else $error("command executed in full power-down");

  property p_pd_exit;
    $fell(full_powerdown) |-> io_supply_wake && is_master;
  endproperty
  a_pd_exit: assert property (p_pd_exit)
    else $error("power-down left without wake");

  property p_mode_up;
    $rose(frame_64) |-> $past(conv_start) || $past(conv_start, 2);
  endproperty
  a_mode_up: assert property (p_mode_up)
    else $error("64-bit mode without conversion start");

  property p_mode_down;
    $fell(frame_64) |-> (reg_wr.addr == A_ADC_FUNC &&
      reg_wr.data == ADC_FUNC_32) || $past(full_powerdown);
  endproperty
  a_mode_down: assert property (p_mode_down)
    else $error("32-bit mode without function write");

  property p_sdo_rise;
    $changed(spi_sdo) && !full_powerdown |-> spi_sclk;
  endproperty
  a_sdo_rise: assert property (p_sdo_rise)
    else $error("serial output moved while clock low");

  property p_ready_push;
    $fell(conv_ready) |-> $past(conv_valid);
  endproperty
  a_ready_push: assert property (p_ready_push)
    else $error("buffer ready dropped without a push");

  property p_dir_reset;
    $fell(rst) |-> chain_one_way;
  endproperty
  a_dir_reset: assert property (p_dir_reset)
    else $error("chain direction not one-way after reset");
endmodule

bind cbm_spi_ctrl cbm_spi_ctrl_checker #(
  .WDT_STEP(WDT_STEP),
  .PD_STEP (PD_STEP)
) u_chk (
  .mclk          (mclk),
  .rst           (rst),
  .spi_cs_n      (spi_cs_n),
  .spi_sclk      (spi_sclk),
  .spi_sdi       (spi_sdi),
  .spi_sdo       (spi_sdo),
  .io_supply_wake(io_supply_wake),
  .is_master     (is_master),
  .conv_start    (conv_start),
  .conv_data     (conv_data),
  .conv_valid    (conv_valid),
  .conv_ready    (conv_ready),
  .reg_wr        (reg_wr),
  .reg_wr_valid  (reg_wr_valid),
  .chain_one_way (chain_one_way),
  .frame_64      (frame_64),
  .full_powerdown(full_powerdown)
);

// [sim/test_chain_spi_command_and_power_control.sv]
`timescale 1ns/1ps
module test_chain_spi_command_and_power_control;
  import cbm_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, io_supply_wake = 1'b1, is_master = 1'b1;
  logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo, conv_start = 1'b0;
  logic conv_valid = 1'b0, conv_ready, reg_wr_valid, chain_one_way;
  logic frame_64, full_powerdown;
  cbm_conv_s conv_data = '0;
  cbm_wr_s   reg_wr;
  logic [63:0] rx;
  logic [31:0] up;
  int err_count = 0, checks_done = 0, pulses = 0;

  always #5 mclk = ~mclk;
  always @(posedge mclk) if (reg_wr_valid === 1'b1) pulses <= pulses + 1;

  cbm_spi_ctrl #(.WDT_STEP(36'd2000), .PD_STEP(36'd30)) dut (
    .mclk(mclk), .rst(rst), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .io_supply_wake(io_supply_wake),
    .is_master(is_master), .conv_start(conv_start), .conv_data(conv_data),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .reg_wr(reg_wr),
    .reg_wr_valid(reg_wr_valid), .chain_one_way(chain_one_way),
    .frame_64(frame_64), .full_powerdown(full_powerdown));
  cbm_host_model host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));

  task automatic check(input string name, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic wr(input logic [4:0] dev, input logic dir,
    input logic [5:0] a, input logic [7:0] d, input logic bad,
    input int ok, input int burst);
    int p0;
    p0 = pulses;
    host.xfer({32'h0, host.cmd(dev, dir, a, d) ^ {31'h0, bad}}, 1'b0,
      burst, rx);
    cyc(10);
    check("write pulses", 64'(pulses - p0), 64'(ok));
    if (ok == 1) check("reg_wr", 64'(reg_wr), 64'({a, d}));
  endtask

  task automatic push(input cbm_conv_s w);
    conv_data = w;
    conv_valid = 1'b1;
    for (int i = 0; i < 200 && conv_ready !== 1'b1; i++) cyc(1);
    if (conv_ready !== 1'b1) err_count++;
    cyc(1);
    conv_valid = 1'b0;
  endtask

  task automatic wake();
    io_supply_wake = 1'b0;
    cyc(10);
    io_supply_wake = 1'b1;
    cyc(10);
    check("wake", 64'(full_powerdown), 64'h0);
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    complete_run();
  end

  initial begin
    cyc(5);
    rst = 1'b0;
    cyc(23000);
    check("pd early", 64'(full_powerdown), 64'h0);
    cyc(2000);
    check("pd expiry", 64'(full_powerdown), 64'h1);
    wr(5'h1f, 1'b1, A_PDT, 8'h00, 1'b0, 0, 32);
    wake();
    // ------------------------------------------------------------
    // addressing, crc and direction
    // ------------------------------------------------------------
    wr(5'h00, 1'b1, A_PDT, 8'h00, 1'b0, 1, 32);
    wr(5'h00, 1'b1, A_PDT, 8'h00, 1'b1, 0, 32);
    wr(5'h05, 1'b1, A_PDT, 8'h00, 1'b0, 0, 32);
    wr(5'h1f, 1'b0, A_PDT, 8'h00, 1'b0, 1, 16);
    check("two-way", 64'(chain_one_way), 64'h0);
    cyc(5000);
    // ------------------------------------------------------------
    // register readback
    // ------------------------------------------------------------
    wr(5'h00, 1'b1, A_RB_SEL, {2'b00, A_WDT}, 1'b0, 1, 32);
    check("one-way", 64'(chain_one_way), 64'h1);
    host.xfer(64'h0, 1'b0, 32, rx);
    up = {5'h00, 1'b0, A_WDT, WDT_RESET, 12'h000};
    up[11:0] = host.crc12(up[31:12]);
    check("readback", rx[31:0], 64'(up));
    // ------------------------------------------------------------
    // conversion stream through the two-entry buffer
    // ------------------------------------------------------------
    conv_start = 1'b1;
    cyc(1);
    conv_start = 1'b0;
    cyc(3);
    check("frame_64", 64'(frame_64), 64'h1);
    push('{6'h01, 3'h1, 55'h0a1});
    push('{6'h02, 3'h2, 55'h0b2});
    cyc(2);
    check("buffer full", 64'(conv_ready), 64'h0);
    conv_data = '{6'h03, 3'h3, 55'h0c3};
    conv_valid = 1'b1;
    host.xfer(64'h0, 1'b1, 16, rx);
    check("conv 1", rx, {6'h01, 3'h1, 55'h0a1});
    cyc(1);
    check("refill", 64'(conv_ready), 64'h0);
    conv_valid = 1'b0;
    host.xfer(64'h0, 1'b1, 32, rx);
    check("conv 2", rx, {6'h02, 3'h2, 55'h0b2});
    host.xfer(64'h0, 1'b1, 32, rx);
    check("conv 3", rx, {6'h03, 3'h3, 55'h0c3});
    host.xfer(64'h0, 1'b1, 32, rx);
    check("reread", rx, {6'h00, 3'h3, 55'h0});
    wr(5'h00, 1'b1, A_ADC_FUNC, ADC_FUNC_32, 1'b0, 1, 32);
    check("frame_32", 64'(frame_64), 64'h0);
    // ------------------------------------------------------------
    // watchdog restart, disable, hardware power-down
    // ------------------------------------------------------------
    wr(5'h00, 1'b1, A_WDT, 8'h01, 1'b0, 1, 32);
    cyc(1500);
    check("wdt short", 64'(full_powerdown), 64'h0);
    cyc(1000);
    check("wdt expiry", 64'(full_powerdown), 64'h1);
    wake();
    wr(5'h00, 1'b1, A_WDT, 8'h00, 1'b0, 1, 32);
    wr(5'h00, 1'b1, A_WDT_KEY, WDT_KEY, 1'b0, 1, 32);
    wr(5'h00, 1'b1, A_WDT, 8'h00, 1'b0, 1, 32);
    cyc(30000);
    check("wdt off", 64'(full_powerdown), 64'h0);
    wr(5'h00, 1'b1, A_CTRL1, 8'h04, 1'b0, 1, 32);
    io_supply_wake = 1'b0;
    cyc(20);
    check("hw pd", 64'(full_powerdown), 64'h1);
    io_supply_wake = 1'b1;
    cyc(20);
    check("hw wake", 64'(full_powerdown), 64'h0);
    wr(5'h00, 1'b1, A_DEV_ADDR, 8'h83, 1'b0, 1, 32);
    wr(5'h03, 1'b1, A_DEV_ADDR, 8'h04, 1'b0, 1, 32);
    wr(5'h00, 1'b1, A_PDT, 8'h00, 1'b0, 0, 32);
    wr(5'h03, 1'b1, A_PDT, 8'h02, 1'b0, 1, 32);
    wr(5'h03, 1'b1, A_CTRL1, 8'h04, 1'b0, 1, 32);
    io_supply_wake = 1'b0;
    cyc(20);
    check("pd timer run", 64'(full_powerdown), 64'h0);
    cyc(50);
    check("pd timer end", 64'(full_powerdown), 64'h1);
    io_supply_wake = 1'b1;
    cyc(20);
    check("timer wake", 64'(full_powerdown), 64'h0);
    complete_run();
  end
endmodule
